// ==== regulator_setpoint_map.svh ====
// register offsets, field positions, reset values and encoding constants
`ifndef REGULATOR_SETPOINT_MAP_SVH
`define REGULATOR_SETPOINT_MAP_SVH
`define BUCK0_VOLTAGE_SETPOINT_ADDR 8'h40
`define BUCK1_VOLTAGE_SETPOINT_ADDR 8'h41
`define BUCK2_VOLTAGE_SETPOINT_ADDR 8'h42
`define BUCK3_VOLTAGE_SETPOINT_ADDR 8'h43
`define PIN7_SEQUENCE_SLOTS_ADDR 8'hab
`define RESET_IO_SEQUENCE_SLOTS_ADDR 8'hac
`define SOURCE_MSB 7
`define SOURCE_LSB 6
`define UP_SLOT_MSB 5
`define UP_SLOT_LSB 3
`define DOWN_SLOT_MSB 2
`define DOWN_SLOT_LSB 0
`define CODE7_MSB 6
`define SPARE_BIT 7
`define SOURCE_SEQ0 2'h0
`define SOURCE_SEQ1_A 2'h1
`define SOURCE_SEQ1_B 2'h2
`define SOURCE_NONE 2'h3
`define BUCK01_RESET 8'h01
`define BUCK23_RESET 8'h00
`define SLOTS_RESET 8'hff
// output in microvolts: buck0/1 base 260000 step 10000, buck2/3 base 600000 step 6250
`define BUCK01_BASE_UV 32'd260000
`define BUCK01_STEP_UV 32'd10000
`define BUCK23_BASE_UV 32'd600000
`define BUCK23_STEP_UV 32'd6250
`endif

// ==== regulator_setpoint_pkg.sv ====
// types shared by the set-point and sequencer slot bank
package regulator_setpoint_pkg;
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001,
    SEQ_UP = 3'b010,
    SEQ_DOWN = 3'b100
  } seq_state_t;
endpackage : regulator_setpoint_pkg

// ==== regulator_setpoint_and_sequencer_slots.sv ====
// register bank for buck set-points and reset-io sequencer slot assignment
`timescale 1ns/1ps
`include "regulator_setpoint_map.svh"

module regulator_setpoint_and_sequencer_slots (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_hit,
  input wire logic seq0_power_up,
  input wire logic seq0_power_down,
  input wire logic seq1_power_up,
  input wire logic seq1_power_down,
  output logic reset_io_active,
  output logic pin7_released,
  output logic [2:0] seq_slot,
  output logic seq_busy,
  output logic [31:0] buck0_target_uv,
  output logic [31:0] buck1_target_uv,
  output logic [31:0] buck2_target_uv,
  output logic [31:0] buck3_target_uv
);

  // software-visible registers; pin 7 slots are kept whole
  // but only its source and slot fields drive anything
  logic [7:0] buck0_voltage_setpoint;
  logic [7:0] buck1_voltage_setpoint;
  logic [7:0] buck2_voltage_setpoint;
  logic [7:0] buck3_voltage_setpoint;
  logic [7:0] reset_io_sequence_slots;
  logic [7:0] pin7_sequence_slots;

  // next values of the bank
  logic [7:0] next_buck0;
  logic [7:0] next_buck1;
  logic [7:0] next_buck2;
  logic [7:0] next_buck3;
  logic [7:0] next_rio_slots;
  logic [7:0] next_pin7_slots;

  // read port
  logic [7:0] next_rdata;
  logic next_hit;

  // slot stepper; seq_sel_one names the sequencer that started the run
  regulator_setpoint_pkg::seq_state_t state;
  regulator_setpoint_pkg::seq_state_t next_state;
  logic [2:0] next_slot;
  logic next_reset_io_active;
  logic next_pin7_released;
  logic seq_sel_one;
  logic next_seq_sel_one;

  // target voltages
  logic [31:0] next_b0_uv;
  logic [31:0] next_b1_uv;
  logic [31:0] next_b2_uv;
  logic [31:0] next_b3_uv;

  // sequencer a resource follows; 2'b11 means it is left out
  // codes 01 and 10 both pick sequencer 1
  function automatic logic uses_seq(input logic [1:0] src, input logic want_one);
    logic r;
    r = 1'b0;
    case (src)
      `SOURCE_SEQ0: r = !want_one;
      `SOURCE_SEQ1_A, `SOURCE_SEQ1_B: r = want_one;
      default: r = 1'b0;
    endcase
    return r;
  endfunction : uses_seq

  // buck0/1 transfer; code zero is reserved so its result is don't care
  // code zero lands one step below the base, at 250000; software avoids it
  function automatic logic [31:0] buck01_uv(input logic [6:0] code);
    logic [31:0] r;
    r = `BUCK01_BASE_UV + (32'(code) - 32'd1) * `BUCK01_STEP_UV;
    return r;
  endfunction : buck01_uv

  // buck2/3 transfer, 6.25mV is exact in microvolts
  // so integer microvolts lose nothing over the whole code range
  function automatic logic [31:0] buck23_uv(input logic [7:0] code);
    logic [31:0] r;
    r = `BUCK23_BASE_UV + 32'(code) * `BUCK23_STEP_UV;
    return r;
  endfunction : buck23_uv

  // a resource acts only in its own slot of its own sequencer
  function automatic logic slot_due(input logic mine, input logic [2:0] slot,
                                    input logic [2:0] pick);
    logic r;
    r = mine && (slot == pick);
    return r;
  endfunction : slot_due

  // register writes; unmapped offsets are dropped without a trace
  always_comb begin
    next_buck0 = buck0_voltage_setpoint;
    next_buck1 = buck1_voltage_setpoint;
    next_buck2 = buck2_voltage_setpoint;
    next_buck3 = buck3_voltage_setpoint;
    next_rio_slots = reset_io_sequence_slots;
    next_pin7_slots = pin7_sequence_slots;
    if (reg_wr) begin
      case (reg_addr)
        // spare bit is stored as written; software keeps it zero
        `BUCK0_VOLTAGE_SETPOINT_ADDR: next_buck0 = reg_wdata;
        `BUCK1_VOLTAGE_SETPOINT_ADDR: next_buck1 = reg_wdata;
        `BUCK2_VOLTAGE_SETPOINT_ADDR: next_buck2 = reg_wdata;
        `BUCK3_VOLTAGE_SETPOINT_ADDR: next_buck3 = reg_wdata;
        `PIN7_SEQUENCE_SLOTS_ADDR: next_pin7_slots = reg_wdata;
        `RESET_IO_SEQUENCE_SLOTS_ADDR: next_rio_slots = reg_wdata;
        default: next_rio_slots = reset_io_sequence_slots;
      endcase
    end
  end

  // bank registers; clk_en low freezes them
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      buck0_voltage_setpoint <= `BUCK01_RESET;
      buck1_voltage_setpoint <= `BUCK01_RESET;
      buck2_voltage_setpoint <= `BUCK23_RESET;
      buck3_voltage_setpoint <= `BUCK23_RESET;
      reset_io_sequence_slots <= `SLOTS_RESET;
      pin7_sequence_slots <= `SLOTS_RESET;
    end else if (clk_en) begin
      buck0_voltage_setpoint <= next_buck0;
      buck1_voltage_setpoint <= next_buck1;
      buck2_voltage_setpoint <= next_buck2;
      buck3_voltage_setpoint <= next_buck3;
      reset_io_sequence_slots <= next_rio_slots;
      pin7_sequence_slots <= next_pin7_slots;
    end
  end

  // read port; a read in the cycle of a write still shows the old value
  // the hit flag tells software that the offset exists
  always_comb begin
    next_rdata = reg_rdata;
    next_hit = 1'b0;
    if (reg_rd) begin
      next_hit = 1'b1;
      case (reg_addr)
        `BUCK0_VOLTAGE_SETPOINT_ADDR: next_rdata = buck0_voltage_setpoint;
        `BUCK1_VOLTAGE_SETPOINT_ADDR: next_rdata = buck1_voltage_setpoint;
        `BUCK2_VOLTAGE_SETPOINT_ADDR: next_rdata = buck2_voltage_setpoint;
        `BUCK3_VOLTAGE_SETPOINT_ADDR: next_rdata = buck3_voltage_setpoint;
        `PIN7_SEQUENCE_SLOTS_ADDR: next_rdata = pin7_sequence_slots;
        `RESET_IO_SEQUENCE_SLOTS_ADDR: next_rdata = reset_io_sequence_slots;
        default: begin
          next_rdata = 8'h00; // unmapped reads zero
          next_hit = 1'b0;
        end
      endcase
    end
  end

  // read data holds until the next read, hit lasts one cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
      reg_hit <= 1'b0;
    end else if (clk_en) begin
      reg_rdata <= next_rdata;
      reg_hit <= next_hit;
    end
  end

  // set-point targets, registered so they stay glitch-free
  // recomputed every cycle, so a write reaches the target two edges later
  always_comb begin
    next_b0_uv = buck01_uv(buck0_voltage_setpoint[`CODE7_MSB:0]);
    next_b1_uv = buck01_uv(buck1_voltage_setpoint[`CODE7_MSB:0]);
    next_b2_uv = buck23_uv(buck2_voltage_setpoint);
    next_b3_uv = buck23_uv(buck3_voltage_setpoint);
  end

  // target registers, frozen with the rest while clk_en is low
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      buck0_target_uv <= 32'h0;
      buck1_target_uv <= 32'h0;
      buck2_target_uv <= 32'h0;
      buck3_target_uv <= 32'h0;
    end else if (clk_en) begin
      buck0_target_uv <= next_b0_uv;
      buck1_target_uv <= next_b1_uv;
      buck2_target_uv <= next_b2_uv;
      buck3_target_uv <= next_b3_uv;
    end
  end

  // slot stepper: one slot per enabled cycle, 0..7 upward on power-up and power-down alike
  always_comb begin
    logic [2:0] up_slot;
    logic [2:0] rio_dn_slot;
    logic [2:0] p7_up_slot;
    logic [2:0] p7_dn_slot;
    logic rio_mine;
    logic p7_mine;

    // slot fields of the two sequencer registers
    up_slot = reset_io_sequence_slots[`UP_SLOT_MSB:`UP_SLOT_LSB];
    rio_dn_slot = reset_io_sequence_slots[`DOWN_SLOT_MSB:`DOWN_SLOT_LSB];
    p7_up_slot = pin7_sequence_slots[`UP_SLOT_MSB:`UP_SLOT_LSB];
    p7_dn_slot = pin7_sequence_slots[`DOWN_SLOT_MSB:`DOWN_SLOT_LSB];

    // which resources the running sequencer owns
    rio_mine = uses_seq(reset_io_sequence_slots[`SOURCE_MSB:`SOURCE_LSB], seq_sel_one);
    p7_mine = uses_seq(pin7_sequence_slots[`SOURCE_MSB:`SOURCE_LSB], seq_sel_one);
    // hold everything unless a slot says otherwise
    next_state = state;
    next_slot = seq_slot;
    next_seq_sel_one = seq_sel_one;
    next_reset_io_active = reset_io_active;
    next_pin7_released = pin7_released;
    case (state)
      regulator_setpoint_pkg::SEQ_IDLE: begin
        next_slot = 3'h0;
        // start pulses while busy are ignored, never queued
        // sequencer 0 wins when both start the same way; a power-up beats a power-down
        if (seq0_power_up || seq1_power_up) begin
          next_state = regulator_setpoint_pkg::SEQ_UP;
          next_seq_sel_one = !seq0_power_up;
        end else if (seq0_power_down || seq1_power_down) begin
          next_state = regulator_setpoint_pkg::SEQ_DOWN;
          next_seq_sel_one = !seq0_power_down;
        end
      end
      regulator_setpoint_pkg::SEQ_UP: begin
        // reset io lets go in its slot; pin 7 follows its own up slot
        if (slot_due(rio_mine, seq_slot, up_slot)) begin
          next_reset_io_active = 1'b0;
        end
        if (slot_due(p7_mine, seq_slot, p7_up_slot)) begin
          next_pin7_released = 1'b1;
        end
        next_slot = seq_slot + 3'h1;
        // slot 7 is the last; the counter wraps to 0 for the next run
        if (seq_slot == 3'h7) begin
          next_state = regulator_setpoint_pkg::SEQ_IDLE;
        end
      end
      regulator_setpoint_pkg::SEQ_DOWN: begin
        // reset io is pulled back in its slot, pin 7 let down in its own
        if (slot_due(rio_mine, seq_slot, rio_dn_slot)) begin
          next_reset_io_active = 1'b1;
        end
        if (slot_due(p7_mine, seq_slot, p7_dn_slot)) begin
          next_pin7_released = 1'b0;
        end
        next_slot = seq_slot + 3'h1;
        if (seq_slot == 3'h7) begin
          next_state = regulator_setpoint_pkg::SEQ_IDLE;
        end
      end
      default: next_state = regulator_setpoint_pkg::SEQ_IDLE;
    endcase
  end

  // stepper state; reset io starts asserted and pin 7 held
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= regulator_setpoint_pkg::SEQ_IDLE;
      seq_slot <= 3'h0;
      seq_sel_one <= 1'b0;
      reset_io_active <= 1'b1;
      pin7_released <= 1'b0;
    end else if (clk_en) begin
      state <= next_state;
      seq_slot <= next_slot;
      seq_sel_one <= next_seq_sel_one;
      reset_io_active <= next_reset_io_active;
      pin7_released <= next_pin7_released;
    end
  end

  // busy straight from the state, so a start is refused at once
  assign seq_busy = (state != regulator_setpoint_pkg::SEQ_IDLE);

endmodule : regulator_setpoint_and_sequencer_slots

// ==== regulator_setpoint_properties.sv ====
// assertions on the register bank and reset-io sequencing
`timescale 1ns/1ps
`include "regulator_setpoint_map.svh"
module regulator_setpoint_properties (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_hit,
  input wire logic seq0_power_up,
  input wire logic seq1_power_down,
  input wire logic reset_io_active,
  input wire logic [2:0] seq_slot,
  input wire logic seq_busy,
  input wire logic [31:0] buck0_target_uv,
  input wire logic [31:0] buck2_target_uv
);
  logic [1:0] src;
  logic [1:0] next_src;
  logic mapped;
  logic up_go;
  logic dn_go;
  // shadow of the source field, since the bank itself is hidden
  always_comb begin
    next_src = src;
    if (clk_en && reg_wr && reg_addr == `RESET_IO_SEQUENCE_SLOTS_ADDR) begin
      next_src = reg_wdata[7:6];
    end
  end
  always_ff @(posedge sys_clk) begin
    src <= rst ? 2'h3 : next_src;
  end
  // start terms; one pulse at a time is assumed by the bench
  assign mapped = reg_addr inside {8'h40, 8'h41, 8'h42, 8'h43, 8'hab, 8'hac};
  assign up_go = clk_en && !seq_busy && seq0_power_up;
  assign dn_go = clk_en && !seq_busy && seq1_power_down && !seq0_power_up;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  a_mapped_hit: assert property (clk_en && reg_rd && mapped |=> reg_hit)
    else $error("no hit on mapped read");
  a_unmapped_zero: assert property (clk_en && reg_rd && !mapped |=> !reg_hit && reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_buck0_code: assert property (clk_en && reg_wr && reg_addr == 8'h40 ##1 clk_en |=>
    buck0_target_uv == `BUCK01_BASE_UV + ({25'h0, $past(reg_wdata[6:0], 2)} - 32'h1) * `BUCK01_STEP_UV)
    else $error("buck0 target wrong");
  a_buck2_code: assert property (clk_en && reg_wr && reg_addr == 8'h42 ##1 clk_en |=>
    buck2_target_uv == `BUCK23_BASE_UV + {24'h0, $past(reg_wdata, 2)} * `BUCK23_STEP_UV)
    else $error("buck2 target wrong");
  a_busy_eight: assert property (up_go |=> seq_busy [*8] ##1 !seq_busy)
    else $error("busy length wrong");
  a_slot_steps: assert property (seq_busy ##1 seq_busy |-> seq_slot == $past(seq_slot) + 3'h1)
    else $error("slot did not step");
  a_none_holds: assert property (seq_busy && src == `SOURCE_NONE |=> $stable(reset_io_active))
    else $error("unassigned reset io moved");
  a_up_release: assert property (up_go && src == `SOURCE_SEQ0 |-> ##10 !reset_io_active)
    else $error("reset io not released");
  a_down_assert: assert property (dn_go && src inside {2'h1, 2'h2} |-> ##10 reset_io_active)
    else $error("reset io not asserted");
  c_up: cover property (up_go);
  c_down: cover property (dn_go);
  c_release: cover property ($fell(reset_io_active));
endmodule : regulator_setpoint_properties

// ==== tb_regulator_setpoint_and_sequencer_slots.sv ====
// random and corner tests of the set-point bank and reset-io slots
`timescale 1ns/1ps
`include "regulator_setpoint_map.svh"
bind regulator_setpoint_and_sequencer_slots regulator_setpoint_properties
  regulator_setpoint_properties_i (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .reg_hit(reg_hit), .seq0_power_up(seq0_power_up),
  .seq1_power_down(seq1_power_down), .reset_io_active(reset_io_active), .seq_slot(seq_slot),
  .seq_busy(seq_busy), .buck0_target_uv(buck0_target_uv), .buck2_target_uv(buck2_target_uv));
module tb_regulator_setpoint_and_sequencer_slots;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [3:0] pulse = 4'h0; // seq0 up, seq0 down, seq1 up, seq1 down
  logic [7:0] reg_rdata;
  logic reg_hit;
  logic reset_io_active;
  logic pin7_released;
  logic clk_en = 1'b1;
  logic [7:0] p7v = 8'h00;
  logic seq_busy;
  logic [31:0] tgt [4];
  logic [31:0] seed = 32'h866a6fd9;
  logic [7:0] ra [6] = '{8'h40, 8'h41, 8'h42, 8'h43, 8'hab, 8'hac};
  logic [7:0] rv [6] = '{8'h01, 8'h01, 8'h00, 8'h00, 8'hff, 8'hff};
  int err_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  regulator_setpoint_and_sequencer_slots regulator_setpoint_and_sequencer_slots_i (
    .sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
    .seq0_power_up(pulse[0]), .seq0_power_down(pulse[1]), .seq1_power_up(pulse[2]),
    .seq1_power_down(pulse[3]), .reset_io_active(reset_io_active),
    .pin7_released(pin7_released),
    .seq_slot(), .seq_busy(seq_busy), .buck0_target_uv(tgt[0]), .buck1_target_uv(tgt[1]),
    .buck2_target_uv(tgt[2]), .buck3_target_uv(tgt[3]));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  // expected output in microvolts for a code
  function automatic logic [31:0] volt(int i, logic [7:0] d);
    if (i < 2) begin
      return `BUCK01_BASE_UV + ({25'h0, d[6:0]} - 32'h1) * `BUCK01_STEP_UV;
    end
    return `BUCK23_BASE_UV + {24'h0, d} * `BUCK23_STEP_UV;
  endfunction : volt
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic finish_test();
    if (err_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge sys_clk);
    {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask : wr
  // read answer is registered, so it is looked at one edge after the request
  task automatic rd(logic [7:0] a, logic [7:0] d, logic h);
    @(negedge sys_clk);
    {reg_rd, reg_addr} = {1'b1, a};
    @(negedge sys_clk);
    reg_rd = 1'b0;
    chk("rdata", {24'h0, reg_rdata}, {24'h0, d});
    chk("hit", {31'h0, reg_hit}, {31'h0, h});
  endtask : rd
  // start one sequence and follow reset io slot by slot
  task automatic run(int p, logic [7:0] v);
    logic cur;
    logic own;
    logic [2:0] s;
    logic cur7;
    logic own7;
    logic [2:0] s7;
    logic e;
    logic e7;
    cur = reset_io_active;
    own = (p < 2) ? (v[7:6] == 2'h0) : (v[7:6] inside {2'h1, 2'h2});
    s = p[0] ? v[2:0] : v[5:3];
    cur7 = pin7_released;
    own7 = (p < 2) ? (p7v[7:6] == 2'h0) : (p7v[7:6] inside {2'h1, 2'h2});
    s7 = p[0] ? p7v[2:0] : p7v[5:3];
    @(negedge sys_clk);
    pulse[p] = 1'b1;
    for (int j = 1; j < 10; j++) begin
      @(negedge sys_clk);
      pulse = 4'h0;
      e = (own && j > s + 1) ? p[0] : cur;
      e7 = (own7 && j > s7 + 1) ? !p[0] : cur7;
      chk("reset_io", {31'h0, reset_io_active}, {31'h0, e});
      chk("pin7", {31'h0, pin7_released}, {31'h0, e7});
      chk("busy", {31'h0, seq_busy}, {31'h0, j < 9});
    end
  endtask : run
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  // hang guard, far above the under 300 cycles the tests need
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      finish_test();
    end
  end
  initial begin
    logic [7:0] d;
    repeat (8) @(negedge sys_clk);
    rst = 1'b0;
    for (int k = 0; k < 6; k++) rd(ra[k], rv[k], 1'b1);
    wr(8'h50, 8'h5a);
    rd(8'h50, 8'h00, 1'b0);
    // nothing may move while clk_en is low
    @(negedge sys_clk);
    clk_en = 1'b0;
    wr(8'h40, 8'h22);
    clk_en = 1'b1;
    rd(8'h40, 8'h01, 1'b1);
    for (int n = 0; n < 24; n++) begin
      d = (n < 4) ? 8'hff : 8'(xs());
      if (n % 4 < 2) d = {1'b0, (d[6:0] == 7'h0) ? 7'h1 : d[6:0]};
      wr(ra[n % 4], d);
      rd(ra[n % 4], d, 1'b1);
      chk("target", tgt[n % 4], volt(n % 4, d));
    end
    // bit 7 cleared so pin 7 always joins one of the sequencers
    p7v = {1'b0, 7'(xs())};
    wr(8'hab, p7v);
    rd(8'hab, p7v, 1'b1);
    for (int n = 0; n < 12; n++) begin
      d = (n == 0) ? 8'hff : (n == 1 || n == 4) ? 8'h38 : 8'(xs());
      wr(`RESET_IO_SEQUENCE_SLOTS_ADDR, d);
      run(n % 4, d);
    end
    finish_test();
  end
endmodule : tb_regulator_setpoint_and_sequencer_slots
